// ### rtl/cgu_pkg.sv
// constants and register map of the clock generation unit
// assumes one 250 MHz mclk domain and an APB slave with 32-bit data
package cgu_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_PLL = 8'h00;
  localparam logic [7:0] OFS_SUB = 8'h04;
  localparam logic [7:0] OFS_WAIT = 8'h08;
  localparam logic [7:0] OFS_CKO = 8'h0C;
  localparam logic [7:0] OFS_DRV = 8'h10;
  localparam logic [7:0] OFS_TRIM = 8'h14;
  localparam logic [7:0] OFS_SYS = 8'h18;
  localparam logic [7:0] OFS_OSC = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  // ==========================================================
  // field positions and reset values
  localparam int MULT_LSB = 8;
  localparam int CKSEL_LSB = 8;
  localparam int CKDIV_LSB = 12;
  localparam int CKEN_BIT = 15;
  localparam logic [5:0] MULT_MIN = 6'h07;
  localparam logic [5:0] MULT_MAX = 6'h17;
  localparam logic [5:0] MULT_RST = 6'h07;
  localparam logic [1:0] PREDIV_MAX = 2'h2;
  localparam logic [4:0] WAIT_MAX = 5'h08;
  localparam logic [2:0] DIV_MAX = 3'h6;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [17:0] WAIT_BASE = 18'h00400;
  // ==========================================================
  // oscillator indices of the sampled source vector
  typedef enum logic [2:0] {
    SRC_SLOW = 3'h0,
    SRC_FAST = 3'h1,
    SRC_MAIN = 3'h2,
    SRC_SUB = 3'h3,
    SRC_PLL = 3'h4,
    SRC_WDT = 3'h5,
    SRC_TOUCH = 3'h6
  } cgu_src_t;
  // ==========================================================
  // main oscillator stop detection window
  localparam int STOP_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int STOP_CYC = STOP_TIME_NS / CLK_PERIOD_NS;
endpackage

// ### rtl/cgu_top.sv
// clock generation unit: source sampling, dividers, glitch-free
// switching, oscillator wait, stop detection and APB registers.
// assumes oscillator pins are asynchronous and far slower than mclk.
// Behaviour
// - one system clock for core, transfers, memories
// - converter clock plus general peripheral clock
// - separate flash interface clock
// - dedicated bus controller clock up to 20 MHz
// - each oscillator except touch passed unchanged to measurement
// - sub clock goes to calendar and low power timer
// - watchdog gets its own oscillator clock
// - low power timer follows selected oscillator
// - main stop forces slow source, allows hiz
// - pll fed by main, predivide 1/2/4
// - pll multiply 4 to 12 by halves
// - multiplier code twice factor minus one
// - fast oscillator at 24, 32 or 48 MHz
// - sub stop bit reset only by power-on
// - wait code zero none, else 1024 doubling
// - wait counts slow oscillator cycles
// - clock output source codes, others refused
// - clock output divide by 1 to 64
// - slow trim code 0 lowest, 255 highest
// - fast frequency after reset from option field
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module cgu_top
  import cgu_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic por_rst,
  input wire logic ce,
  input wire logic [6:0] osc_pins,
  input wire logic [1:0] opt_fast_freq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic system_clock,
  output logic general_peripheral_clock,
  output logic converter_peripheral_clock,
  output logic flash_interface_clock,
  output logic bus_controller_clock,
  output logic [5:0] accuracy_measure_clock,
  output logic calendar_sub_clock,
  output logic watchdog_clock,
  output logic low_power_timer_clock,
  output logic clock_output_pin,
  output logic motor_pin_hiz,
  output logic main_osc_stable,
  output logic [1:0] pll_prediv,
  output logic [5:0] pll_multiplier_field,
  output logic [1:0] fast_oscillator_frequency_field,
  output logic main_oscillator_drive_bit,
  output logic [7:0] slow_oscillator_trim_field
);
  // ==========================================================
  // helpers
  // divided clock tap: code 0 passes the source itself
  function automatic logic div_tap(input logic src, input logic [5:0] cnt, input logic [2:0] code);
    return (code == 3'h0) ? src : cnt[code - 3'h1];
  endfunction
  // wait length in slow oscillator cycles
  function automatic logic [17:0] wait_len(input logic [4:0] code);
    return (code == 5'h00) ? 18'h00000 : WAIT_BASE << (code - 5'h01);
  endfunction
  // clock output source code to sampled index
  function automatic logic [2:0] cko_idx(input logic [3:0] code);
    return (code == 4'h8) ? SRC_TOUCH : code[2:0];
  endfunction
  // ==========================================================
  // registers
  logic [5:0] mult_r; // pll multiplier code
  logic [1:0] prediv_r; // pll predivide code
  logic sub_stop_r; // sub oscillator stop, power-on only
  logic [4:0] wait_code_r; // main oscillator wait code
  logic [3:0] cko_sel_r; // clock output source code
  logic [2:0] cko_div_r; // clock output divide code
  logic cko_en_r; // clock output pin enable
  logic drive_r; // main oscillator drive bit
  logic [7:0] trim_r; // slow oscillator trim
  logic [2:0] sys_src_r; // requested system source
  logic [2:0] div_sys_r, div_pb_r, div_pd_r, div_fl_r, div_can_r;
  logic main_en_r; // main oscillator enable
  logic det_en_r; // slow source force enable on stop
  logic hiz_en_r; // motor pin hiz enable on stop
  logic [1:0] fast_fq_r; // fast oscillator frequency code
  logic [1:0] lpt_src_r; // low power timer source
  logic opt_load_r; // first cycle after reset release
  logic stop_flag_r; // main oscillator stop seen
  logic [6:0] sync1_r, sync2_r, prev_r; // pin samplers
  logic [2:0] sys_sel_r, cko_cur_r; // switched selections
  logic [5:0] sys_cnt_r, can_cnt_r, cko_cnt_r; // divider counters
  logic [17:0] wait_cnt_r; // slow edges since main enable
  logic [9:0] stop_cnt_r; // mclk cycles since last main edge
  // ==========================================================
  // apb decode
  logic wr_en, setup;
  logic [31:0] rd_nxt;
  logic bad_wr;
  assign setup = psel && !penable;
  assign wr_en = ce && psel && penable && pwrite && !bad_wr;
  assign pready = 1'b1;
  // legality of written codes; refused writes keep the old value
  always_comb begin
    bad_wr = 1'b0;
    unique case (paddr)
      OFS_PLL: bad_wr = pwdata[13:8] < MULT_MIN || pwdata[13:8] > MULT_MAX
                        || pwdata[1:0] > PREDIV_MAX;
      OFS_WAIT: bad_wr = pwdata[4:0] > WAIT_MAX;
      OFS_CKO: bad_wr = (pwdata[11:8] > 4'h4 && pwdata[11:8] != 4'h8)
                        || pwdata[14:12] > DIV_MAX;
      OFS_SYS: bad_wr = pwdata[2:0] > 3'h4 || pwdata[6:4] > DIV_MAX
                        || pwdata[10:8] > DIV_MAX || pwdata[14:12] > DIV_MAX
                        || pwdata[18:16] > DIV_MAX || pwdata[22:20] > DIV_MAX;
      OFS_OSC: bad_wr = pwdata[5:4] == 2'h3 || pwdata[9:8] == 2'h3;
      OFS_SUB, OFS_DRV, OFS_TRIM, OFS_STAT: bad_wr = 1'b0;
      default: bad_wr = 1'b1;
    endcase
  end
  // read mux
  always_comb begin
    rd_nxt = 32'h00000000;
    unique case (paddr)
      OFS_PLL: rd_nxt = {18'h0, mult_r, 6'h0, prediv_r};
      OFS_SUB: rd_nxt = {31'h0, sub_stop_r};
      OFS_WAIT: rd_nxt = {27'h0, wait_code_r};
      OFS_CKO: rd_nxt = {16'h0, cko_en_r, cko_div_r, cko_sel_r, 8'h0};
      OFS_DRV: rd_nxt = {31'h0, drive_r};
      OFS_TRIM: rd_nxt = {24'h0, trim_r};
      OFS_SYS: rd_nxt = {9'h0, div_can_r, 1'b0, div_fl_r, 1'b0, div_pd_r,
                         1'b0, div_pb_r, 1'b0, div_sys_r, 1'b0, sys_src_r};
      OFS_OSC: rd_nxt = {22'h0, lpt_src_r, 2'h0, fast_fq_r, 1'b0, hiz_en_r,
                         det_en_r, main_en_r};
      OFS_STAT: rd_nxt = {29'h0, sys_sel_r == SRC_SLOW, stop_flag_r, main_osc_stable};
      default: rd_nxt = 32'h00000000;
    endcase
  end
  // read data captured in setup so it comes from flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata <= rd_nxt;
      pslverr <= pwrite && bad_wr;
    end
  end
  // ==========================================================
  // control registers under the normal reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      mult_r <= MULT_RST;
      prediv_r <= 2'h0;
      wait_code_r <= 5'h00;
      {cko_en_r, cko_div_r, cko_sel_r} <= 8'h00;
      drive_r <= 1'b0;
      trim_r <= TRIM_RST;
      sys_src_r <= SRC_SLOW;
      {div_sys_r, div_pb_r, div_pd_r, div_fl_r, div_can_r} <= 15'h0000;
      {main_en_r, det_en_r, hiz_en_r} <= 3'h0;
      fast_fq_r <= 2'h0;
      lpt_src_r <= 2'h0;
      opt_load_r <= 1'b1;
    end else if (ce) begin
      opt_load_r <= 1'b0;
      if (opt_load_r) begin
        fast_fq_r <= opt_fast_freq;
      end
      if (wr_en) begin
        unique case (paddr)
          OFS_PLL: begin
            mult_r <= pwdata[13:8];
            prediv_r <= pwdata[1:0];
          end
          OFS_WAIT: wait_code_r <= pwdata[4:0];
          OFS_CKO: {cko_en_r, cko_div_r, cko_sel_r} <= pwdata[15:8];
          OFS_DRV: drive_r <= pwdata[0];
          OFS_TRIM: trim_r <= pwdata[7:0];
          OFS_SYS: begin
            sys_src_r <= pwdata[2:0];
            div_sys_r <= pwdata[6:4];
            div_pb_r <= pwdata[10:8];
            div_pd_r <= pwdata[14:12];
            div_fl_r <= pwdata[18:16];
            div_can_r <= pwdata[22:20];
          end
          OFS_OSC: begin
            {main_en_r, det_en_r, hiz_en_r} <= {pwdata[0], pwdata[1], pwdata[2]};
            fast_fq_r <= pwdata[5:4];
            lpt_src_r <= pwdata[9:8];
          end
          default: ;
        endcase
      end
    end
  end
  // sub oscillator stop survives every reset except power-on
  always_ff @(posedge mclk) begin
    if (por_rst) begin
      sub_stop_r <= 1'b0;
    end else if (wr_en && paddr == OFS_SUB) begin
      sub_stop_r <= pwdata[0];
    end
  end
  // ==========================================================
  // oscillator pin sampling: two flops, then a third for edges
  always_ff @(posedge mclk) begin
    if (srst) begin
      {sync1_r, sync2_r, prev_r} <= 21'h000000;
    end else if (ce) begin
      sync1_r <= osc_pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  logic sys_lvl, sys_rise, cko_lvl, cko_rise, slow_rise, main_rise;
  logic [2:0] sys_want, cko_want;
  assign sys_lvl = sync2_r[sys_sel_r];
  assign sys_rise = sys_lvl && !prev_r[sys_sel_r];
  assign cko_lvl = sync2_r[cko_cur_r];
  assign cko_rise = cko_lvl && !prev_r[cko_cur_r];
  assign slow_rise = sync2_r[SRC_SLOW] && !prev_r[SRC_SLOW];
  assign main_rise = sync2_r[SRC_MAIN] && !prev_r[SRC_MAIN];
  assign sys_want = (stop_flag_r && det_en_r) ? SRC_SLOW : sys_src_r;
  assign cko_want = cko_idx(cko_sel_r);
  // ==========================================================
  // glitch-free switching: move only while old and new are low
  always_ff @(posedge mclk) begin
    if (srst) begin
      sys_sel_r <= SRC_SLOW;
      cko_cur_r <= SRC_SLOW;
    end else if (ce) begin
      if (sys_want != sys_sel_r && !sys_lvl && !sync2_r[sys_want]) begin
        sys_sel_r <= sys_want;
      end
      if (cko_want != cko_cur_r && !cko_lvl && !sync2_r[cko_want]) begin
        cko_cur_r <= cko_want;
      end
    end
  end
  // divider counters step on each rising edge of their source
  always_ff @(posedge mclk) begin
    if (srst) begin
      {sys_cnt_r, can_cnt_r, cko_cnt_r} <= 18'h00000;
    end else if (ce) begin
      if (sys_rise) begin
        sys_cnt_r <= sys_cnt_r + 6'h01;
      end
      if (main_rise) begin
        can_cnt_r <= can_cnt_r + 6'h01;
      end
      if (cko_rise) begin
        cko_cnt_r <= cko_cnt_r + 6'h01;
      end
    end
  end
  // ==========================================================
  // clock outputs, all registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      {system_clock, general_peripheral_clock, converter_peripheral_clock} <= 3'h0;
      {flash_interface_clock, bus_controller_clock, clock_output_pin} <= 3'h0;
      {calendar_sub_clock, watchdog_clock, low_power_timer_clock} <= 3'h0;
      accuracy_measure_clock <= 6'h00;
      motor_pin_hiz <= 1'b0;
    end else if (ce) begin
      system_clock <= div_tap(sys_lvl, sys_cnt_r, div_sys_r);
      general_peripheral_clock <= div_tap(sys_lvl, sys_cnt_r, div_pb_r);
      converter_peripheral_clock <= div_tap(sys_lvl, sys_cnt_r, div_pd_r);
      flash_interface_clock <= div_tap(sys_lvl, sys_cnt_r, div_fl_r);
      // main resonator tops out at 20 MHz, so undivided stays in range
      bus_controller_clock <= div_tap(sync2_r[SRC_MAIN], can_cnt_r, div_can_r);
      clock_output_pin <= cko_en_r && div_tap(cko_lvl, cko_cnt_r, cko_div_r);
      accuracy_measure_clock <= sync2_r[5:0];
      calendar_sub_clock <= sync2_r[SRC_SUB] && !sub_stop_r;
      watchdog_clock <= sync2_r[SRC_WDT];
      unique case (lpt_src_r)
        2'h0: low_power_timer_clock <= sync2_r[SRC_SUB] && !sub_stop_r;
        2'h1: low_power_timer_clock <= sync2_r[SRC_WDT];
        default: low_power_timer_clock <= sync2_r[SRC_SLOW];
      endcase
      motor_pin_hiz <= stop_flag_r && hiz_en_r;
    end
  end
  // ==========================================================
  // main oscillator wait counted in slow oscillator edges
  always_ff @(posedge mclk) begin
    if (srst) begin
      wait_cnt_r <= 18'h00000;
      main_osc_stable <= 1'b0;
    end else if (ce) begin
      if (!main_en_r) begin
        wait_cnt_r <= 18'h00000;
        main_osc_stable <= 1'b0;
      end else if (wait_cnt_r >= wait_len(wait_code_r)) begin
        main_osc_stable <= 1'b1;
      end else if (slow_rise) begin
        wait_cnt_r <= wait_cnt_r + 18'h00001;
      end
    end
  end
  // stop detection: no main edge for the whole window while stable;
  // the event wins over a same-cycle write-one clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      stop_cnt_r <= 10'h000;
      stop_flag_r <= 1'b0;
    end else if (ce) begin
      if (main_rise || !main_osc_stable) begin
        stop_cnt_r <= 10'h000;
      end else if (stop_cnt_r != STOP_CYC[9:0]) begin
        stop_cnt_r <= stop_cnt_r + 10'h001;
      end
      if (stop_cnt_r >= STOP_CYC[9:0] - 10'h001 && !main_rise && main_osc_stable) begin
        stop_flag_r <= 1'b1;
      end else if (wr_en && paddr == OFS_STAT && pwdata[1]) begin
        stop_flag_r <= 1'b0;
      end
    end
  end
  // analog trims driven straight from registers
  assign pll_prediv = prediv_r;
  assign pll_multiplier_field = mult_r;
  assign fast_oscillator_frequency_field = fast_fq_r;
  assign main_oscillator_drive_bit = drive_r;
  assign slow_oscillator_trim_field = trim_r;
  // ==========================================================
  // assertions
  a_stop_forces_slow: assert property (@(posedge mclk) disable iff (srst)
    ce && stop_flag_r && det_en_r |-> ##[0:400] sys_sel_r == SRC_SLOW)
    else $error("stop did not force slow source");
  a_hiz_follows: assert property (@(posedge mclk) disable iff (srst)
    ce && stop_flag_r && hiz_en_r |=> motor_pin_hiz) else $error("hiz not driven after stop");
  a_stable_wait: assert property (@(posedge mclk) disable iff (srst)
    $rose(main_osc_stable) |-> $past(wait_cnt_r) >= wait_len($past(wait_code_r)))
    else $error("stable before wait elapsed");
  a_bad_mult_kept: assert property (@(posedge mclk) disable iff (srst)
    ce && psel && penable && pwrite && paddr == OFS_PLL && pwdata[13:8] > MULT_MAX
    |=> $stable(mult_r))
    else $error("prohibited multiplier taken");
  a_bad_cko_kept: assert property (@(posedge mclk) disable iff (srst)
    ce && psel && penable && pwrite && paddr == OFS_CKO && pwdata[11:8] == 4'h5
    |=> $stable(cko_sel_r))
    else $error("prohibited clock output source taken");
  a_switch_low: assert property (@(posedge mclk) disable iff (srst)
    $changed(sys_sel_r) |-> !$past(sys_lvl)) else $error("system source switched while high");
  a_cal_path: assert property (@(posedge mclk) disable iff (srst)
    ce |=> calendar_sub_clock == ($past(sync2_r[SRC_SUB]) && !$past(sub_stop_r)))
    else $error("calendar clock mismatch");
  a_wdt_path: assert property (@(posedge mclk) disable iff (srst)
    ce |=> watchdog_clock == $past(sync2_r[SRC_WDT])) else $error("watchdog clock mismatch");
  a_sub_stop_kept: assert property (@(posedge mclk) disable iff (por_rst)
    srst && !(psel && penable && pwrite && paddr == OFS_SUB) |=> $stable(sub_stop_r))
    else $error("sub stop changed by plain reset");
  c_stop_seen: cover property (@(posedge mclk) disable iff (srst) $rose(stop_flag_r));
  c_stable_seen: cover property (@(posedge mclk) disable iff (srst) $rose(main_osc_stable));
  c_sys_switch: cover property (@(posedge mclk) disable iff (srst) sys_sel_r == SRC_PLL);
endmodule // cgu_top

// ### verification/clock_generation_unit_tb.sv
// self-checking bench of the clock generation unit: apb register tasks,
// oscillator pin model and edge-rate counting of the derived clocks.
// assumes cgu_top with pready constant 1 and one 250 MHz mclk domain.
`timescale 1ns/1ns
module clock_generation_unit_tb
  import cgu_pkg::*;
;
  // ==========================================================
  // stimulus and observation signals
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic por_rst = 1'b1; // power-up asserts both resets
  logic ce = 1'b1;
  logic [1:0] opt_fast_freq = 2'h2; // option field fixed at 48 MHz code
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, system_clock, general_peripheral_clock, converter_peripheral_clock;
  logic flash_interface_clock, bus_controller_clock, calendar_sub_clock, watchdog_clock;
  logic low_power_timer_clock, clock_output_pin, motor_pin_hiz, main_osc_stable, main_oscillator_drive_bit;
  logic [5:0] accuracy_measure_clock, pll_multiplier_field;
  logic [1:0] pll_prediv, fast_oscillator_frequency_field;
  logic [7:0] slow_oscillator_trim_field;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // ==========================================================
  // oscillator model: each pin toggles every half[i] mclk while run[i]
  int half [7] = '{4, 3, 6, 9, 5, 7, 8};
  int ocnt [7];
  logic [6:0] run = 7'h7F;
  logic [6:0] gen = 7'h00;
  wire [6:0] osc_pins = gen & run; // a stopped pin sits low
  wire [14:0] mon = {accuracy_measure_clock, clock_output_pin, calendar_sub_clock, watchdog_clock,
    low_power_timer_clock, bus_controller_clock, flash_interface_clock, converter_peripheral_clock,
    general_peripheral_clock, system_clock};
  always #2 mclk = ~mclk;
  // pins are far slower than mclk, as the synchronisers expect
  always @(posedge mclk) begin
    for (int i = 0; i < 7; i++) begin
      if (ocnt[i] >= half[i] - 1) begin
        ocnt[i] <= 0;
        gen[i] <= ~gen[i];
      end else begin
        ocnt[i] <= ocnt[i] + 1;
      end
    end
  end
  cgu_top dut (.mclk(mclk), .srst(srst), .por_rst(por_rst), .ce(ce), .osc_pins(osc_pins),
    .opt_fast_freq(opt_fast_freq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .system_clock(system_clock),
    .general_peripheral_clock(general_peripheral_clock),
    .converter_peripheral_clock(converter_peripheral_clock), .flash_interface_clock(flash_interface_clock),
    .bus_controller_clock(bus_controller_clock), .accuracy_measure_clock(accuracy_measure_clock),
    .calendar_sub_clock(calendar_sub_clock), .watchdog_clock(watchdog_clock),
    .low_power_timer_clock(low_power_timer_clock), .clock_output_pin(clock_output_pin),
    .motor_pin_hiz(motor_pin_hiz), .main_osc_stable(main_osc_stable), .pll_prediv(pll_prediv),
    .pll_multiplier_field(pll_multiplier_field), .fast_oscillator_frequency_field(fast_oscillator_frequency_field),
    .main_oscillator_drive_bit(main_oscillator_drive_bit), .slow_oscillator_trim_field(slow_oscillator_trim_field));
  // ==========================================================
  // closing report and comparison helpers
  task conclude();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, then access held until pready at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int w;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    q = prdata;
    e = pslverr;
    chk(32'(pready), 32'h00000001);
    psel <= 1'b0;
    penable <= 1'b0;
    // callers look at outputs only once the access edge has settled
    @(negedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(32'(e), 32'(ee));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk(q & m, x);
    chk(32'(e), 32'h00000000);
  endtask
  // rising edges of one monitored clock over 800 settled cycles
  task rate(input int idx, input int x);
    int n;
    logic p;
    n = 0;
    repeat (20) @(negedge mclk);
    p = mon[idx];
    repeat (800) begin
      @(negedge mclk);
      if (mon[idx] === 1'b1 && p === 1'b0) n++;
      p = mon[idx];
    end
    n_compared++;
    if (n < x - 2 || n > x + 2) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, n, x);
    end
  endtask
  task pulse(input logic p);
    @(posedge mclk);
    if (p) por_rst <= 1'b1;
    else srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    por_rst <= 1'b0;
  endtask
  // ceiling well above the roughly 30k cycles the sequence needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end
  // ==========================================================
  // main sequence
  logic [3:0] sels [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
  logic [31:0] v;
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    por_rst <= 1'b0;
    rd(OFS_PLL, 32'h00000700, ALL);
    rd(OFS_TRIM, 32'h00000080, ALL);
    chk(32'(fast_oscillator_frequency_field), 32'h00000002);
    for (int m = 7; m <= 23; m++) begin
      v = 32'(m) << MULT_LSB | 32'(m % 3);
      wr(OFS_PLL, v, 1'b0);
      rd(OFS_PLL, v, ALL);
      chk(32'(pll_multiplier_field), 32'(m));
      chk(32'(pll_prediv), 32'(m % 3));
    end
    wr(OFS_PLL, 32'h00000600, 1'b1);
    wr(OFS_PLL, 32'h00001800, 1'b1);
    wr(OFS_PLL, 32'h00001703, 1'b1);
    rd(OFS_PLL, 32'h00001702, ALL);
    for (int w = 0; w <= 8; w++) begin
      wr(OFS_WAIT, 32'(w), 1'b0);
      rd(OFS_WAIT, 32'(w), ALL);
    end
    wr(OFS_WAIT, 32'h00000009, 1'b1);
    rd(OFS_WAIT, 32'h00000008, ALL);
    for (int k = 0; k <= 6; k++) begin
      v = 32'h00008000 | 32'(k) << CKDIV_LSB | 32'(sels[k % 6]) << CKSEL_LSB;
      wr(OFS_CKO, v, 1'b0);
      rd(OFS_CKO, v, ALL);
    end
    wr(OFS_CKO, 32'h00008500, 1'b1);
    wr(OFS_CKO, 32'h00008700, 1'b1);
    wr(OFS_CKO, 32'h0000F000, 1'b1);
    rd(OFS_CKO, 32'h0000E000, ALL);
    wr(OFS_CKO, 32'h00009000, 1'b0);
    rate(8, 50);
    wr(OFS_CKO, 32'h00008800, 1'b0);
    rate(8, 50);
    wr(OFS_CKO, 32'h00008400, 1'b0);
    rate(8, 80);
    wr(OFS_DRV, 32'h00000001, 1'b0);
    rd(OFS_DRV, 32'h00000001, ALL);
    chk(32'(main_oscillator_drive_bit), 32'h00000001);
    for (int t = 0; t < 2; t++) begin
      v = t ? 32'h000000FF : 32'h00000000;
      wr(OFS_TRIM, v, 1'b0);
      rd(OFS_TRIM, v, ALL);
      chk(32'(slow_oscillator_trim_field), v);
    end
    // unmapped place: read gives zero, write is refused
    rd(8'h24, 32'h00000000, ALL);
    wr(8'h24, 32'h00000001, 1'b1);
    // sub stop survives a plain reset, only power-on clears it
    rate(7, 44);
    wr(OFS_SUB, 32'h00000001, 1'b0);
    rate(7, 0);
    pulse(1'b0);
    rd(OFS_SUB, 32'h00000001, ALL);
    pulse(1'b1);
    rd(OFS_SUB, 32'h00000000, ALL);
    for (int f = 0; f < 3; f++) begin
      wr(OFS_OSC, 32'(f) << 4, 1'b0);
      chk(32'(fast_oscillator_frequency_field), 32'(f));
    end
    wr(OFS_OSC, 32'h00000030, 1'b1);
    rate(5, 44);
    wr(OFS_OSC, 32'h00000120, 1'b0);
    rate(5, 57);
    wr(OFS_OSC, 32'h00000220, 1'b0);
    rate(5, 100);
    wr(OFS_OSC, 32'h00000320, 1'b1);
    rate(6, 57);
    for (int i = 0; i < 6; i++) rate(9 + i, 400 / half[i]);
    // divider codes: general /2, converter /4, bus controller /2
    wr(OFS_SYS, 32'h00102100, 1'b0);
    rate(0, 100);
    rate(1, 50);
    rate(2, 25);
    rate(3, 100);
    rate(4, 33);
    wr(OFS_SYS, 32'h00000005, 1'b1);
    wr(OFS_SYS, 32'h00102104, 1'b0);
    rate(0, 80);
    // stable flag only once 1024 slow rises have passed
    wr(OFS_WAIT, 32'h00000001, 1'b0);
    wr(OFS_OSC, 32'h00000021, 1'b0);
    repeat (8000) @(posedge mclk);
    chk(32'(main_osc_stable), 32'h00000000);
    for (int w = 0; w < 600 && main_osc_stable !== 1'b1; w++) @(posedge mclk);
    chk(32'(main_osc_stable), 32'h00000001);
    wr(OFS_SYS, 32'h00000002, 1'b0);
    rate(0, 66);
    // clock enable low freezes the derived clocks; only the system clock is counted here
    @(posedge mclk);
    ce <= 1'b0;
    rate(0, 0);
    @(posedge mclk);
    ce <= 1'b1;
    wr(OFS_OSC, 32'h00000027, 1'b0);
    chk(32'(motor_pin_hiz), 32'h00000000);
    @(posedge mclk);
    run[2] <= 1'b0;
    repeat (700) @(posedge mclk);
    rd(OFS_STAT, 32'h00000006, 32'h00000006);
    chk(32'(motor_pin_hiz), 32'h00000001);
    rate(0, 100);
    // clear loses while main is still dead, then holds once it runs
    wr(OFS_STAT, 32'h00000002, 1'b0);
    rd(OFS_STAT, 32'h00000002, 32'h00000002);
    @(posedge mclk);
    run[2] <= 1'b1;
    repeat (20) @(posedge mclk);
    wr(OFS_STAT, 32'h00000002, 1'b0);
    rd(OFS_STAT, 32'h00000000, 32'h00000002);
    conclude();
  end
endmodule // clock_generation_unit_tb
